// ===== logic/pslc_top.sv
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module pslc_top #(
  parameter int BLINK_CYCLES = pslc_pkg::BLINK_CYC
) (
  input  wire logic        clk_in,                 // system clock, 20 MHz
  input  wire logic        rst_in,                 // async reset, active high
  input  wire logic        chip_rst_n_in,          // chip reset pin, active low
  input  wire logic [4:0]  reg_addr_in,            // register address
  input  wire logic [15:0] reg_wdata_in,           // register write data
  input  wire logic        reg_wr_in,              // write strobe
  input  wire logic        reg_rd_in,              // read strobe
  output logic      [15:0] reg_rdata_out,          // read data, cycle after strobe
  input  wire logic [2:0]  station_address_strap_in,  // address strap pins, level
  output logic      [2:0]  station_address_strap_out, // address pins, driven value
  output logic      [2:0]  station_address_strap_oe_out, // address pins enable
  input  wire logic [2:0]  mode_strap_in,          // interface mode pins, level
  output logic      [2:0]  mode_strap_out,         // mode pins, driven value
  output logic      [2:0]  mode_strap_oe_out,      // mode pins enable
  input  wire logic        second_indicator_in,    // indicator pin, level
  output logic             second_indicator_out,   // indicator pin, driven value
  output logic             second_indicator_oe_out, // indicator pin enable
  input  wire logic        link_clk_in,            // MAC-side reference clock
  input  wire logic        tx_en_in,               // transmit enable from MAC
  input  wire logic [3:0]  txd_in,                 // transmit data from MAC
  output logic      [3:0]  rxd_out,                // receive data to MAC
  output logic             rx_dv_out,              // receive valid / carrier valid
  output logic      [3:0]  line_tx_data_out,       // nibble toward line side
  output logic             line_tx_valid_out,      // one-cycle nibble strobe
  input  wire logic [3:0]  line_rx_data_in,        // nibble from line side
  input  wire logic        line_rx_valid_in,       // nibble valid from line side
  output logic             line_rx_ready_out       // line side may present nibble
);

  // ---------------- system domain: pin synchronisers ----------------
  pslc_pkg::pslc_strap_t strap_s1;
  pslc_pkg::pslc_strap_t strap_s2;
  logic                  rstn_s1;
  logic                  rstn_s2;
  wire pslc_pkg::pslc_strap_t strap_raw = '{cfg: mode_strap_in,
                                          addr: station_address_strap_in,
                                          speed: second_indicator_in};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_s1 <= '0;
      strap_s2 <= '0;
      rstn_s1  <= 1'h0;
      rstn_s2  <= 1'h0;
    end else begin
      strap_s1 <= strap_raw;
      strap_s2 <= strap_s1;
      rstn_s1  <= chip_rst_n_in;
      rstn_s2  <= rstn_s1;
    end
  end

  wire chip_rst = !rstn_s2;

  // ---------------- strap window ----------------
  // window outlasts the synchroniser so the last sample predates the drivers
  logic [1:0]            strap_cnt;
  logic                  pins_oe;
  pslc_pkg::pslc_strap_t strap;
  wire strap_phase = (strap_cnt != 2'h0);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_cnt <= pslc_pkg::STRAP_CYC;
    end else if (chip_rst) begin
      strap_cnt <= pslc_pkg::STRAP_CYC;
    end else if (strap_phase) begin
      strap_cnt <= strap_cnt - 2'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pins_oe <= 1'h0;
    end else begin
      pins_oe <= !strap_phase;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap <= '0;
    end else if (strap_phase) begin
      strap <= strap_s2;
    end
  end

  // ---------------- interface mode decode ----------------
  wire mode_rmii     = (strap.cfg == pslc_pkg::CFG_RMII);
  wire mode_mii      = (strap.cfg == pslc_pkg::CFG_MII);
  wire mode_pre      = (strap.cfg == pslc_pkg::CFG_MII_PRE);
  wire mode_reserved = !(mode_rmii || mode_mii || mode_pre);
  wire [4:0] station_address = {pslc_pkg::ADDR_UPPER, strap.addr};

  // ---------------- registers ----------------
  logic       speed_100;
  logic [1:0] ind_mode;

  wire wr_ctrl = reg_wr_in && (reg_addr_in == pslc_pkg::REG_CTRL);
  wire wr_ind  = reg_wr_in && (reg_addr_in == pslc_pkg::REG_IND_CFG);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      speed_100 <= pslc_pkg::SPEED_RST;
    end else if (strap_phase) begin
      speed_100 <= strap_s2.speed;
    end else if (wr_ctrl) begin
      speed_100 <= reg_wdata_in[pslc_pkg::SPEED_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ind_mode <= pslc_pkg::IND_MODE_RST;
    end else if (chip_rst) begin
      ind_mode <= pslc_pkg::IND_MODE_RST;
    end else if (wr_ind) begin
      ind_mode <= reg_wdata_in[pslc_pkg::IND_MODE_HI:pslc_pkg::IND_MODE_LO];
    end
  end

  logic act_seen;
  logic ind_level;

  wire [15:0] rd_ctrl = {2'h0, speed_100, 13'h0000};
  wire [15:0] rd_ind  = {ind_mode, 14'h0000};
  wire [15:0] rd_stat = {4'h0, act_seen, mode_reserved, mode_pre, mode_rmii,
                         strap.cfg, station_address};
  wire [15:0] rd_sel  = (reg_addr_in == pslc_pkg::REG_CTRL)    ? rd_ctrl :
                        (reg_addr_in == pslc_pkg::REG_IND_CFG) ? rd_ind  :
                        (reg_addr_in == pslc_pkg::REG_STAT)    ? rd_stat : 16'h0000;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_sel : 16'h0000;
    end
  end

  // ---------------- activity crossing, link to system ----------------
  logic act_tgl;
  logic act_s1;
  logic act_s2;
  logic act_s3;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_s1 <= 1'h0;
      act_s2 <= 1'h0;
      act_s3 <= 1'h0;
    end else begin
      act_s1 <= act_tgl;
      act_s2 <= act_s1;
      act_s3 <= act_s2;
    end
  end

  wire act_event = act_s2 ^ act_s3;

  // ---------------- blink timer and indicator ----------------
  logic [31:0] blink_cnt;
  wire         blink_tick = (blink_cnt == 32'(BLINK_CYCLES - 1));

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      blink_cnt <= 32'h0000_0000;
    end else if (chip_rst || blink_tick) begin
      blink_cnt <= 32'h0000_0000;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  // event wins over the clear on the tick
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_seen <= 1'h0;
    end else if (act_event) begin
      act_seen <= 1'h1;
    end else if (blink_tick || chip_rst) begin
      act_seen <= 1'h0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ind_level <= 1'h1;
    end else if (chip_rst) begin
      ind_level <= 1'h1;
    end else if (!blink_tick) begin
      ind_level <= ind_level;
    end else if (act_seen) begin
      ind_level <= !ind_level;
    end else begin
      ind_level <= 1'h1;
    end
  end

  // reserved modes leave the indicator off
  wire next_indicator = (ind_mode == pslc_pkg::IND_SPEED)    ? !speed_100 :
                        (ind_mode == pslc_pkg::IND_ACTIVITY) ? ind_level  :
                        1'h1;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      second_indicator_out         <= 1'h1;
      second_indicator_oe_out      <= 1'h0;
      station_address_strap_out    <= 3'h0;
      station_address_strap_oe_out <= 3'h0;
      mode_strap_out               <= 3'h0;
      mode_strap_oe_out            <= 3'h0;
    end else begin
      second_indicator_out         <= next_indicator;
      second_indicator_oe_out      <= pins_oe;
      station_address_strap_out    <= strap.addr;
      station_address_strap_oe_out <= {3{pins_oe}};
      mode_strap_out               <= strap.cfg;
      mode_strap_oe_out            <= {3{pins_oe}};
    end
  end

  // ---------------- link domain ----------------
  // mode is static after the strap window, so a level sync suffices
  logic lk_rmii_s1;
  logic lk_rmii;

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lk_rmii_s1 <= 1'h0;
      lk_rmii    <= 1'h0;
    end else begin
      lk_rmii_s1 <= mode_rmii;
      lk_rmii    <= lk_rmii_s1;
    end
  end

  // chip reset reaches the link logic through its own two flops;
  // chip_rst is a single flop output, so it cannot glitch on the way
  logic lk_rst_s1;
  logic lk_rst;

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lk_rst_s1 <= 1'h1;
      lk_rst    <= 1'h1;
    end else begin
      lk_rst_s1 <= chip_rst;
      lk_rst    <= lk_rst_s1;
    end
  end

  // transmit: MII nibble per cycle, RMII two dibits low first
  logic       tx_half;
  logic [1:0] tx_low;
  pslc_pkg::pslc_nibble_t tx_nib;

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_half <= 1'h0;
      tx_low  <= 2'h0;
      tx_nib  <= '0;
    end else if (!tx_en_in || lk_rst) begin
      tx_half <= 1'h0;
      tx_nib  <= '0;
    end else if (!lk_rmii) begin
      tx_nib  <= '{data: txd_in, valid: 1'h1};
    end else if (!tx_half) begin
      tx_half <= 1'h1;
      tx_low  <= txd_in[1:0];
      tx_nib  <= '0;
    end else begin
      tx_half <= 1'h0;
      tx_nib  <= '{data: {txd_in[1:0], tx_low}, valid: 1'h1};
    end
  end

  assign line_tx_data_out  = tx_nib.data;
  assign line_tx_valid_out = tx_nib.valid;

  // receive: RMII splits each nibble over two periods, stalling the source
  logic       rx_half;
  logic [1:0] rx_high;
  wire        rx_take = line_rx_valid_in && line_rx_ready_out;
  wire        next_rx_half = lk_rmii && !rx_half && rx_take;

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_half           <= 1'h0;
      rx_high           <= 2'h0;
      rxd_out           <= 4'h0;
      rx_dv_out         <= 1'h0;
      line_rx_ready_out <= 1'h1;
    end else if (lk_rst) begin
      // nothing reaches the mac while the chip is held in reset
      rx_half           <= 1'h0;
      rxd_out           <= 4'h0;
      rx_dv_out         <= 1'h0;
      line_rx_ready_out <= 1'h1;
    end else begin
      rx_half           <= next_rx_half;
      line_rx_ready_out <= !next_rx_half;
      if (rx_half) begin
        rxd_out   <= {2'h0, rx_high};
        rx_dv_out <= 1'h1;
      end else if (rx_take && lk_rmii) begin
        rx_high   <= line_rx_data_in[3:2];
        rxd_out   <= {2'h0, line_rx_data_in[1:0]};
        rx_dv_out <= 1'h1;
      end else if (rx_take) begin
        rxd_out   <= line_rx_data_in;
        rx_dv_out <= 1'h1;
      end else begin
        rxd_out   <= 4'h0;
        rx_dv_out <= 1'h0;
      end
    end
  end

  // one toggle per frame start keeps the crossing slower than the sampler
  logic lk_busy;
  wire  busy_now = tx_en_in || rx_dv_out;

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lk_busy <= 1'h0;
      act_tgl <= 1'h0;
    end else begin
      lk_busy <= busy_now;
      if (busy_now && !lk_busy) begin
        act_tgl <= !act_tgl;
      end
    end
  end

endmodule // pslc_top

// ===== logic/pslc_pkg.sv
package pslc_pkg;

  // register offsets, 5-bit management address space
  localparam logic [4:0]  REG_CTRL      = 5'h00;
  localparam logic [4:0]  REG_STAT      = 5'h1D;
  localparam logic [4:0]  REG_IND_CFG   = 5'h1E;

  // field positions
  localparam int          SPEED_BIT     = 13;
  localparam int          IND_MODE_HI   = 15;
  localparam int          IND_MODE_LO   = 14;

  // reset values
  localparam logic [1:0]  IND_MODE_RST  = 2'h0;
  localparam logic        SPEED_RST     = 1'h1;

  // indicator modes
  localparam logic [1:0]  IND_SPEED     = 2'h0;
  localparam logic [1:0]  IND_ACTIVITY  = 2'h1;

  // interface mode strap codes
  localparam logic [2:0]  CFG_MII       = 3'h0;
  localparam logic [2:0]  CFG_RMII      = 3'h1;
  localparam logic [2:0]  CFG_MII_PRE   = 3'h4;

  // station address upper bits are fixed
  localparam logic [1:0]  ADDR_UPPER    = 2'h0;

  // strap window after chip reset release, in clk_in cycles
  localparam logic [1:0]  STRAP_CYC     = 2'h3;

  // timing
  localparam longint      CLK_HZ        = 20000000;
  localparam int          BLINK_MS      = 50;
  localparam int          BLINK_CYC     = int'((CLK_HZ * BLINK_MS) / 1000);

  typedef struct packed {
    logic [2:0] cfg;
    logic [2:0] addr;
    logic       speed;
  } pslc_strap_t;

  typedef struct packed {
    logic [3:0] data;
    logic       valid;
  } pslc_nibble_t;

endpackage

// ===== test/pslc_top_props.sv
`timescale 1ns/1ns
module pslc_top_props (
  input wire logic        clk_in,                  // clock
  input wire logic        rst_in,                  // reset
  input wire logic        chip_rst_n_in,           // chip reset
  input wire logic [4:0]  reg_addr_in,             // address
  input wire logic [15:0] reg_wdata_in,            // write data
  input wire logic        reg_wr_in,               // write
  input wire logic        reg_rd_in,               // read
  input wire logic [15:0] reg_rdata_out,           // read data
  input wire logic [2:0]  mode_strap_out,          // mode pins
  input wire logic [2:0]  mode_strap_oe_out,       // mode enables
  input wire logic        second_indicator_out,    // indicator
  input wire logic        second_indicator_oe_out, // indicator enable
  input wire logic        link_clk_in,             // link clock
  input wire logic        tx_en_in,                // tx enable
  input wire logic [3:0]  txd_in,                  // tx data
  input wire logic [3:0]  rxd_out,                 // rx data
  input wire logic        rx_dv_out,               // rx valid
  input wire logic [3:0]  line_tx_data_out,        // line nibble
  input wire logic        line_tx_valid_out,       // line strobe
  input wire logic [3:0]  line_rx_data_in,         // line rx nibble
  input wire logic        line_rx_valid_in,        // line rx valid
  input wire logic        line_rx_ready_out        // line rx ready
);
  logic [1:0] mode_q;
  wire        mii  = (&mode_strap_oe_out) && mode_strap_out == pslc_pkg::CFG_MII;
  wire        rmii = (&mode_strap_oe_out) && mode_strap_out == pslc_pkg::CFG_RMII;
  // shadow mode clears before the design does, so it can only under-report
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) mode_q <= pslc_pkg::IND_MODE_RST;
    else if (!chip_rst_n_in) mode_q <= pslc_pkg::IND_MODE_RST;
    else if (reg_wr_in && reg_addr_in == pslc_pkg::REG_IND_CFG) mode_q <= reg_wdata_in[15:14];
  end
  a_oe_window: assert property (@(posedge clk_in) disable iff (rst_in)
    !chip_rst_n_in |-> ##[1:5] (!second_indicator_oe_out && mode_strap_oe_out == 3'h0))
    else $error("strap pins still driven in reset");
  a_mode_readback: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == pslc_pkg::REG_IND_CFG && chip_rst_n_in |=> reg_rdata_out == {$past(mode_q), 14'h0})
    else $error("indicator mode readback wrong");
  a_ind_speed: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_wr_in && reg_addr_in == pslc_pkg::REG_CTRL && second_indicator_oe_out && chip_rst_n_in
    |-> ##3 (mode_q != pslc_pkg::IND_SPEED || second_indicator_out == !$past(reg_wdata_in[13], 3)))
    else $error("speed indicator level wrong");
  a_ind_reserved: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode_q[1] && second_indicator_oe_out) [*4] |-> second_indicator_out)
    else $error("reserved indicator mode not high");
  a_mii_tx: assert property (@(posedge link_clk_in) disable iff (rst_in)
    mii && tx_en_in |=> line_tx_valid_out && line_tx_data_out == $past(txd_in))
    else $error("mii transmit nibble lost");
  a_tx_idle: assert property (@(posedge link_clk_in) disable iff (rst_in)
    !tx_en_in |=> !line_tx_valid_out)
    else $error("transmit nibble without enable");
  a_mii_rx: assert property (@(posedge link_clk_in) disable iff (rst_in)
    mii && line_rx_valid_in && line_rx_ready_out |=> rx_dv_out && rxd_out == $past(line_rx_data_in))
    else $error("mii receive nibble wrong");
  a_rmii_rx: assert property (@(posedge link_clk_in) disable iff (rst_in)
    rmii && line_rx_valid_in && line_rx_ready_out |=> rx_dv_out && rxd_out == {2'h0, $past(line_rx_data_in[1:0])}
    ##1 rx_dv_out && rxd_out == {2'h0, $past(line_rx_data_in[3:2], 2)})
    else $error("rmii receive dibits wrong");
  a_rmii_stall: assert property (@(posedge link_clk_in) disable iff (rst_in)
    rmii && line_rx_valid_in && line_rx_ready_out |=> !line_rx_ready_out ##1 line_rx_ready_out)
    else $error("rmii receive stall wrong");
endmodule // pslc_top_props

bind pslc_top pslc_top_props u_props (
  .clk_in(clk_in), .rst_in(rst_in), .chip_rst_n_in(chip_rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .mode_strap_out(mode_strap_out), .mode_strap_oe_out(mode_strap_oe_out),
  .second_indicator_out(second_indicator_out), .second_indicator_oe_out(second_indicator_oe_out),
  .link_clk_in(link_clk_in), .tx_en_in(tx_en_in), .txd_in(txd_in), .rxd_out(rxd_out), .rx_dv_out(rx_dv_out),
  .line_tx_data_out(line_tx_data_out), .line_tx_valid_out(line_tx_valid_out),
  .line_rx_data_in(line_rx_data_in), .line_rx_valid_in(line_rx_valid_in), .line_rx_ready_out(line_rx_ready_out)
);

// ===== test/pslc_mac_model.sv
`timescale 1ns/1ns
module pslc_mac_model (
  input  wire logic       link_clk_in, // link clock
  output logic            tx_en_out,   // transmit enable
  output logic      [3:0] txd_out,     // transmit data
  input  wire logic [3:0] rxd_in,      // receive data
  input  wire logic       rx_dv_in     // receive valid
);
  logic [3:0] rx_q[$];
  initial begin
    tx_en_out = 1'b0;
    txd_out   = 4'h0;
  end
  // gap sets how slowly the mac comes back; idle data is inverted, not held
  task automatic send(input logic [3:0] d[$], input int gap);
    foreach (d[i]) begin
      @(posedge link_clk_in);
      tx_en_out <= 1'b1;
      txd_out   <= d[i];
    end
    @(posedge link_clk_in);
    tx_en_out <= 1'b0;
    txd_out   <= ~txd_out;
    repeat (gap) @(posedge link_clk_in);
  endtask
  always @(posedge link_clk_in) begin
    if (rx_dv_in === 1'b1) rx_q.push_back(rxd_in);
  end
endmodule // pslc_mac_model

// ===== test/pslc_top_tb.sv
`timescale 1ns/1ns
module pslc_top_tb;
  typedef struct packed {logic [2:0] a; logic [2:0] m; logic s; logic [15:0] st;} pslc_row_t;
  localparam pslc_row_t ROWS [5] = '{'{3'h1, 3'h0, 1'h1, 16'h0001}, '{3'h7, 3'h1, 1'h0, 16'h0127},
    '{3'h5, 3'h4, 1'h1, 16'h0285}, '{3'h2, 3'h3, 1'h1, 16'h0462}, '{3'h6, 3'h7, 1'h0, 16'h04E6}};
  logic        clk_in, rst_in, crst_n, lclk, wr, rd, lv, ind_ext, tx_en, ind_out, ind_oe, dv, ltv, lrdy, prev;
  logic [4:0]  addr;
  logic [15:0] wd, rdata, got;
  logic [3:0]  ld, txd, rxd, ltd;
  logic [2:0]  a_ext, m_ext, a_out, a_oe, m_out, m_oe;
  logic [3:0]  tx_q[$];
  int          n_mismatch, checks, tog;
  // pins read the driven value once enabled, else the pull or strap resistor
  wire  [2:0]  a_pin = (a_oe & a_out) | (~a_oe & a_ext);
  wire  [2:0]  m_pin = (m_oe & m_out) | (~m_oe & m_ext);
  wire         i_pin = ind_oe ? ind_out : ind_ext;
  pslc_top #(.BLINK_CYCLES(16)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .chip_rst_n_in(crst_n), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .station_address_strap_in(a_pin),
    .station_address_strap_out(a_out), .station_address_strap_oe_out(a_oe), .mode_strap_in(m_pin),
    .mode_strap_out(m_out), .mode_strap_oe_out(m_oe), .second_indicator_in(i_pin),
    .second_indicator_out(ind_out), .second_indicator_oe_out(ind_oe), .link_clk_in(lclk), .tx_en_in(tx_en),
    .txd_in(txd), .rxd_out(rxd), .rx_dv_out(dv), .line_tx_data_out(ltd), .line_tx_valid_out(ltv),
    .line_rx_data_in(ld), .line_rx_valid_in(lv), .line_rx_ready_out(lrdy));
  pslc_mac_model mac (.link_clk_in(lclk), .tx_en_out(tx_en), .txd_out(txd), .rxd_in(rxd), .rx_dv_in(dv));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #16 lclk = ~lclk;
  end
  always @(posedge lclk) begin
    if (ltv === 1'b1) tx_q.push_back(ltd);
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmpq(ref logic [3:0] q[$], input logic [3:0] e[$]);
    repeat (4) @(posedge lclk);
    chk(16'(q.size()), 16'(e.size()));
    foreach (e[i]) chk(16'(q[i]), 16'(e[i]));
    q.delete();
  endtask
  task automatic wr16(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr   <= 1'b1;
    addr <= a;
    wd   <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd16(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_in);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic strap(input logic [2:0] a, input logic [2:0] m, input logic s);
    @(posedge clk_in);
    a_ext   <= a;
    m_ext   <= m;
    ind_ext <= s;
    crst_n  <= 1'b0;
    repeat (5) @(posedge clk_in);
    #1 chk(16'({a_oe, m_oe, ind_oe}), 16'h0);
    @(posedge clk_in);
    crst_n <= 1'b1;
    repeat (10) @(posedge clk_in);
    #1 chk(16'({a_oe, m_oe, ind_oe}), 16'h7F);
    chk(16'(a_out), 16'(a));
    chk(16'(m_out), 16'(m));
    chk(16'(ind_out), 16'(!s));
  endtask
  task automatic line_put(input logic [3:0] d);
    @(posedge lclk);
    lv <= 1'b1;
    ld <= d;
    do @(posedge lclk); while (lrdy !== 1'b1);
    lv <= 1'b0;
    ld <= ~d;
  endtask
  task automatic end_of_test;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {rst_in, crst_n, wr, rd, lv, ind_ext, addr, wd, ld, a_ext, m_ext} = {4'hC, 2'h1, 5'h0, 16'h0, 4'hF, 6'h08};
    n_mismatch = 0;
    checks = 0;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    rd16(pslc_pkg::REG_STAT, got);
    chk(got & 16'h07FF, 16'h0001);
    $display("pull defaults done");
    foreach (ROWS[i]) begin
      strap(ROWS[i].a, ROWS[i].m, ROWS[i].s);
      rd16(pslc_pkg::REG_STAT, got);
      chk(got & 16'h07FF, ROWS[i].st);
      rd16(pslc_pkg::REG_CTRL, got);
      chk(16'(got[13]), 16'(ROWS[i].s));
    end
    $display("strap table done");
    strap(3'h1, 3'h0, 1'h1);
    for (int s = 0; s < 2; s++) begin
      wr16(pslc_pkg::REG_CTRL, 16'(s) << 13);
      repeat (4) @(posedge clk_in);
      #1 chk(16'(ind_out), 16'(1 - s));
    end
    mac.send('{4'hA, 4'h5, 4'h0, 4'hF}, 2);
    cmpq(tx_q, '{4'hA, 4'h5, 4'h0, 4'hF});
    line_put(4'h3);
    line_put(4'hC);
    cmpq(mac.rx_q, '{4'h3, 4'hC});
    $display("mii link done");
    wr16(pslc_pkg::REG_IND_CFG, 16'h4000);
    rd16(pslc_pkg::REG_IND_CFG, got);
    chk(got, 16'h4000);
    repeat (40) @(posedge clk_in);
    #1 chk(16'(ind_out), 16'h1);
    tog = 0;
    prev = ind_out;
    fork
      repeat (6) mac.send('{4'h1, 4'h2}, 15);
      repeat (80) begin
        @(posedge clk_in);
        if (ind_out !== prev) tog++;
        prev = ind_out;
      end
    join
    chk(16'(tog >= 2), 16'h1);
    tx_q.delete();
    for (int m = 2; m < 4; m++) begin
      wr16(pslc_pkg::REG_IND_CFG, 16'(m) << 14);
      mac.send('{4'h7}, 2);
      repeat (40) @(posedge clk_in);
      #1 chk(16'(ind_out), 16'h1);
      rd16(pslc_pkg::REG_IND_CFG, got);
      chk(got, 16'(m) << 14);
    end
    tx_q.delete();
    $display("indicator done");
    strap(3'h1, 3'h1, 1'h1);
    mac.send('{4'h1, 4'h2, 4'h3, 4'h0, 4'h2}, 3);
    cmpq(tx_q, '{4'h9, 4'h3});
    line_put(4'hD);
    cmpq(mac.rx_q, '{4'h1, 4'h3});
    $display("rmii link done");
    wr16(pslc_pkg::REG_IND_CFG, 16'h4000);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    rd16(pslc_pkg::REG_IND_CFG, got);
    chk(got, 16'h0000);
    rd16(pslc_pkg::REG_STAT, got);
    chk(got & 16'h07FF, 16'h0121);
    rd16(5'h05, got);
    chk(got, 16'h0000);
    $display("reset and map done");
    end_of_test();
  end
endmodule // pslc_top_tb
